// file: hdl/apfc_defines.vh
// constants for the amplifier protection and fault controller
`ifndef APFC_DEFINES_VH
`define APFC_DEFINES_VH
// register sub-addresses on the serial control port
`define APFC_REG_ERR_STATUS  8'h02
`define APFC_REG_SYS_CTRL2   8'h05
`define APFC_REG_RECOV_DLY   8'h1c
`define APFC_REG_OUT_MUX     8'h25
// error status bit positions
`define APFC_ERR_OC_BIT      0
`define APFC_ERR_OT_BIT      1
`define APFC_ERR_UV_BIT      2
// system control 2: single-ended plus bridged mode enable
`define APFC_MODE21_BIT      2
// reset values
`define APFC_ERR_STATUS_RST  8'h00
`define APFC_SYS_CTRL2_RST   8'h00
`define APFC_RECOV_DLY_RST   8'h01
`define APFC_OUT_MUX_RST     32'h01002345
// strapped 7-bit slave addresses
`define APFC_ADDR_STRAP_HI   7'h1b
`define APFC_ADDR_STRAP_LO   7'h1a
// output configurations
`define APFC_CFG_STEREO      2'h0
`define APFC_CFG_PARALLEL    2'h1
`define APFC_CFG_21          2'h2
// timing
`define APFC_CLK_FREQ_MHZ    20
`define APFC_RECOV_UNIT_US   1000
`define APFC_OC_PERSIST_NS   2000
`define APFC_OC_PERSIST_CYC  ((`APFC_OC_PERSIST_NS * `APFC_CLK_FREQ_MHZ) / 1000)
`define APFC_STRAP_SETTLE    2'h3
`endif

// file: hdl/apfc_top.v
// protection, fault pin and serial control slave of a class-d amplifier
`include "apfc_defines.vh"
module apfc_top #(
  parameter [23:0] RECOV_UNIT_CYC = `APFC_RECOV_UNIT_US * `APFC_CLK_FREQ_MHZ
) (
  input  wire        mclk_i,
  input  wire        sys_rst_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output wire        sda_o,
  output wire        sda_oe_o,
  input  wire        adr_fault_i,
  output wire        adr_fault_o,
  output wire        adr_fault_oe_o,
  input  wire        parallel_bridge_select_i,
  input  wire [3:0]  oc_i,
  input  wire        ot_trip_i,
  input  wire        ot_cool_i,
  input  wire        uv_analog_i,
  input  wire [1:0]  uv_power_stage_i,
  input  wire        por_power_stage_ok_i,
  input  wire        por_analog_ok_i,
  input  wire [7:0]  soft_start_timing_pin_i,
  input  wire [7:0]  duty_target_i,
  output wire [3:0]  bridge_hiz_o,
  output wire [7:0]  duty_o,
  output wire [1:0]  output_config_o,
  output wire [31:0] output_mux_o,
  output wire        playback_o
);
  // serial slave states
  localparam [8:0] ST_IDLE = 9'h001, ST_ADDR = 9'h002, ST_AACK = 9'h004,
                   ST_SUB  = 9'h008, ST_SACK = 9'h010, ST_WR   = 9'h020,
                   ST_WACK = 9'h040, ST_RD   = 9'h080, ST_RACK = 9'h100;
  // protection states
  localparam [3:0] PS_POR = 4'h1, PS_RAMP = 4'h2, PS_RUN = 4'h4, PS_PROT = 4'h8;

  // last byte index of a register; only the output mux spans four bytes
  function [1:0] reg_last;
    input [7:0] a;
    begin
      reg_last = (a == `APFC_REG_OUT_MUX) ? 2'h3 : 2'h0;
    end
  endfunction

  // every pin but duty_target_i passes two flops; the first stage feeds only the second
  wire [22:0] pin_w = {soft_start_timing_pin_i, por_analog_ok_i, por_power_stage_ok_i,
                       uv_power_stage_i, uv_analog_i, ot_cool_i, ot_trip_i, oc_i,
                       parallel_bridge_select_i, adr_fault_i, sda_i, scl_i};
  reg  [22:0] sync1_r;
  reg  [22:0] sync2_r;
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      // bus lines idle high; every fault and supply flag starts inactive
      sync1_r <= 23'h000003;
      sync2_r <= 23'h000003;
    end
    else
    begin
      sync1_r <= pin_w;
      sync2_r <= sync1_r;
    end
  end
  wire       scl_s  = sync2_r[0];
  wire       sda_s  = sync2_r[1];
  wire       adr_s  = sync2_r[2];
  wire       par_s  = sync2_r[3];
  wire [3:0] oc_s   = sync2_r[7:4];
  wire       ott_s  = sync2_r[8];
  wire       otc_s  = sync2_r[9];
  wire       uv_any = sync2_r[10] | sync2_r[11] | sync2_r[12];
  wire       por_ok = sync2_r[13] & sync2_r[14];
  wire [7:0] ss_s   = sync2_r[22:15];

  // bus edge and condition detection
  reg        scl_d_r;
  reg        sda_d_r;
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire i2c_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire i2c_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  reg  [8:0]  st_r;
  reg  [3:0]  bit_r;
  reg  [7:0]  sh_r;
  reg  [7:0]  tx_r;
  reg  [7:0]  sub_r;
  reg  [1:0]  bidx_r;
  reg         rw_r;
  reg         nack_r;
  reg         sda_oe_r;
  reg  [6:0]  dev_addr_r;
  reg  [7:0]  err_r;
  reg  [7:0]  ctrl2_r;
  reg  [7:0]  recov_r;
  reg  [31:0] mux_r;
  reg  [23:0] mux_sh_r;
  reg  [7:0]  rd_byte;

  // read data for the current pointer, most significant byte first
  always @*
  begin
    rd_byte = 8'h00;
    if (sub_r == `APFC_REG_ERR_STATUS)
      rd_byte = err_r;
    else if (sub_r == `APFC_REG_SYS_CTRL2)
      rd_byte = ctrl2_r;
    else if (sub_r == `APFC_REG_RECOV_DLY)
      rd_byte = recov_r;
    else if (sub_r == `APFC_REG_OUT_MUX)
      rd_byte = mux_r[8*(3-bidx_r) +: 8];
  end

  wire wr_stb = scl_fall & (st_r == ST_WR) & (bit_r == 4'h8);
  wire rd_adv = scl_fall & (((st_r == ST_AACK) & rw_r) | ((st_r == ST_RACK) & ~nack_r));
  wire ptr_adv = wr_stb | rd_adv;

  // serial control slave; bits sampled at scl rise, driven after scl fall
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= ST_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      sub_r <= 8'h00;
      bidx_r <= 2'h0;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (i2c_start)
    begin
      st_r <= ST_ADDR;
      bit_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end
    else if (i2c_stop)
    begin
      st_r <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end
    else if (scl_rise)
    begin
      if ((st_r == ST_ADDR) | (st_r == ST_SUB) | (st_r == ST_WR))
      begin
        sh_r <= {sh_r[6:0], sda_s};
        bit_r <= bit_r + 4'h1;
      end
      else if (st_r == ST_RD)
        bit_r <= bit_r + 4'h1;
      else if (st_r == ST_RACK)
        nack_r <= sda_s;
    end
    else if (scl_fall)
    begin
      case (st_r)
        ST_ADDR:
          if (bit_r == 4'h8)
          begin
            if (sh_r[7:1] == dev_addr_r)
            begin
              st_r <= ST_AACK;
              sda_oe_r <= 1'b1;
              rw_r <= sh_r[0];
            end
            else
              st_r <= ST_IDLE; // other slave addressed: stay off the bus
          end
        ST_AACK, ST_RACK:
          if (rw_r & ~((st_r == ST_RACK) & nack_r))
          begin
            st_r <= ST_RD;
            tx_r <= rd_byte;
            sda_oe_r <= ~rd_byte[7];
            bit_r <= 4'h0;
          end
          else
          begin
            st_r <= (st_r == ST_RACK) ? ST_IDLE : ST_SUB;
            sda_oe_r <= 1'b0;
            bit_r <= 4'h0;
          end
        ST_SUB:
          if (bit_r == 4'h8)
          begin
            st_r <= ST_SACK;
            sda_oe_r <= 1'b1;
            sub_r <= sh_r;
            bidx_r <= 2'h0;
          end
        ST_SACK, ST_WACK:
        begin
          st_r <= ST_WR;
          sda_oe_r <= 1'b0;
          bit_r <= 4'h0;
        end
        ST_WR:
          if (bit_r == 4'h8)
          begin
            st_r <= ST_WACK;
            sda_oe_r <= 1'b1;
          end
        ST_RD:
          if (bit_r == 4'h8)
          begin
            st_r <= ST_RACK;
            sda_oe_r <= 1'b0;
          end
          else
          begin
            tx_r <= {tx_r[6:0], 1'b0};
            sda_oe_r <= ~tx_r[6];
          end
        default:
          st_r <= ST_IDLE;
      endcase
      // pointer walks through bytes, then on to the next register
      if (ptr_adv)
      begin
        if (bidx_r == reg_last(sub_r))
        begin
          sub_r <= sub_r + 8'h01;
          bidx_r <= 2'h0;
        end
        else
          bidx_r <= bidx_r + 2'h1;
      end
    end
  end

  // protection state
  reg  [3:0]  ps_r;
  reg  [1:0]  strap_cnt_r;
  reg         strap_done_r;
  reg  [7:0]  oc_cnt_r;
  reg         oc_latch_r;
  reg         ot_act_r;
  reg  [23:0] unit_cnt_r;
  reg  [7:0]  dly_cnt_r;
  reg  [7:0]  ss_cnt_r;
  reg  [7:0]  duty_r;
  reg  [3:0]  hiz_r;

  wire fault_now = oc_latch_r | ot_act_r | uv_any;
  wire [7:0] err_set = {5'h00, uv_any, ot_act_r, oc_latch_r};
  wire wr_err = wr_stb & (sub_r == `APFC_REG_ERR_STATUS);

  // registers; a write to error status can only clear, a new event wins
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      err_r <= `APFC_ERR_STATUS_RST;
      ctrl2_r <= `APFC_SYS_CTRL2_RST;
      recov_r <= `APFC_RECOV_DLY_RST;
      mux_r <= `APFC_OUT_MUX_RST;
      mux_sh_r <= 24'h000000;
    end
    else
    begin
      err_r <= (wr_err ? (err_r & sh_r) : err_r) | err_set;
      if (wr_stb & (sub_r == `APFC_REG_SYS_CTRL2))
        ctrl2_r <= sh_r;
      if (wr_stb & (sub_r == `APFC_REG_RECOV_DLY))
        recov_r <= sh_r;
      if (wr_stb & (sub_r == `APFC_REG_OUT_MUX))
      begin
        // whole word commits only on its last byte
        if (bidx_r == 2'h3)
          mux_r <= {mux_sh_r, sh_r};
        else
          mux_sh_r <= {mux_sh_r[15:0], sh_r};
      end
    end
  end

  // power-up, protection, recovery and soft-start sequencing
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      ps_r <= PS_POR;
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
      dev_addr_r <= `APFC_ADDR_STRAP_LO;
      oc_cnt_r <= 8'h00;
      oc_latch_r <= 1'b0;
      ot_act_r <= 1'b0;
      unit_cnt_r <= 24'h000000;
      dly_cnt_r <= 8'h00;
      ss_cnt_r <= 8'h00;
      duty_r <= 8'h00;
      hiz_r <= 4'hf;
    end
    else
    begin
      // strap read once after release, pin never sampled again
      if (~strap_done_r)
      begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
        if (strap_cnt_r == `APFC_STRAP_SETTLE)
        begin
          strap_done_r <= 1'b1;
          dev_addr_r <= adr_s ? `APFC_ADDR_STRAP_HI : `APFC_ADDR_STRAP_LO;
        end
      end
      // thermal hysteresis: trip above hot point, release after cooling
      if (ott_s)
        ot_act_r <= 1'b1;
      else if (otc_s)
        ot_act_r <= 1'b0;
      // short overcurrent is only limited; persistent overcurrent latches
      if (|oc_s)
      begin
        if (oc_cnt_r == `APFC_OC_PERSIST_CYC)
          oc_latch_r <= 1'b1;
        else
          oc_cnt_r <= oc_cnt_r + 8'h01;
      end
      else
        oc_cnt_r <= 8'h00;
      case (ps_r)
        PS_POR:
        begin
          oc_cnt_r <= 8'h00;
          oc_latch_r <= 1'b0;
          duty_r <= 8'h00;
          if (por_ok & strap_done_r)
            ps_r <= PS_RAMP;
        end
        PS_RAMP, PS_RUN:
          if (fault_now)
          begin
            ps_r <= PS_PROT;
            duty_r <= 8'h00;
            unit_cnt_r <= 24'h000000;
            dly_cnt_r <= 8'h00;
          end
          else if (ps_r == PS_RUN)
            duty_r <= duty_target_i;
          else if (duty_r >= duty_target_i)
            ps_r <= PS_RUN;
          else if (ss_cnt_r >= ss_s)
          begin
            ss_cnt_r <= 8'h00;
            duty_r <= duty_r + 8'h01;
          end
          else
            ss_cnt_r <= ss_cnt_r + 8'h01;
        PS_PROT:
          if (dly_cnt_r >= recov_r)
          begin
            dly_cnt_r <= 8'h00;
            unit_cnt_r <= 24'h000000;
            if (~((|oc_s) | ot_act_r | uv_any))
            begin
              ps_r <= PS_RAMP;
              oc_latch_r <= 1'b0;
              ss_cnt_r <= 8'h00;
            end
          end
          else if (unit_cnt_r == RECOV_UNIT_CYC - 24'h000001)
          begin
            unit_cnt_r <= 24'h000000;
            dly_cnt_r <= dly_cnt_r + 8'h01;
          end
          else
            unit_cnt_r <= unit_cnt_r + 24'h000001;
        default:
          ps_r <= PS_POR;
      endcase
      // outputs hi-z outside ramp and run, on undervoltage or on latched faults
      if (((ps_r != PS_RAMP) & (ps_r != PS_RUN)) | fault_now)
        hiz_r <= 4'hf;
      else if (par_s)
        hiz_r <= {{2{|oc_s[3:2]}}, {2{|oc_s[1:0]}}};
      else
        hiz_r <= oc_s;
    end
  end

  assign sda_o          = 1'b0;
  assign sda_oe_o       = sda_oe_r;
  assign adr_fault_o    = 1'b0;
  // open drain: once the strap is read, pull low while any status bit or live fault stands
  assign adr_fault_oe_o = strap_done_r & ((|err_r) | fault_now);
  assign bridge_hiz_o   = hiz_r;
  assign duty_o         = duty_r;
  assign output_mux_o   = mux_r;
  assign playback_o     = (ps_r == PS_RUN);
  assign output_config_o = par_s ? `APFC_CFG_PARALLEL :
                           (ctrl2_r[`APFC_MODE21_BIT] ? `APFC_CFG_21 : `APFC_CFG_STEREO);
endmodule // apfc_top

// file: verification/apfc_assertions.sv
// concurrent checks on the protection controller ports
module apfc_assertions (
  input logic       mclk_i,
  input logic       sys_rst_i,
  input logic       scl_i,
  input logic       sda_oe_o,
  input logic       adr_fault_oe_o,
  input logic       parallel_bridge_select_i,
  input logic [3:0] oc_i,
  input logic       ot_trip_i,
  input logic       uv_analog_i,
  input logic [1:0] uv_power_stage_i,
  input logic [3:0] bridge_hiz_o,
  input logic [7:0] duty_o,
  input logic [1:0] output_config_o,
  input logic       playback_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic [5:0] oc_run_r;
  wire        uv_any = uv_analog_i | (|uv_power_stage_i);
  // consecutive overcurrent cycles, saturating so a long fault stays visible
  always @(posedge mclk_i)
    if (sys_rst_i || oc_i == 4'h0)
      oc_run_r <= 6'h00;
    else if (oc_run_r != 6'h3f)
      oc_run_r <= oc_run_r + 6'h01;
  chk_uv_hiz:
    assert property (uv_any |-> ##[0:3] bridge_hiz_o == 4'hf)
    else $error("undervoltage left a bridge driven");
  chk_oc_latch:
    assert property (oc_run_r == 6'h2d |-> bridge_hiz_o == 4'hf && !playback_o)
    else $error("long overcurrent not latched");
  chk_pair_off:
    assert property (parallel_bridge_select_i && oc_i[0] |-> ##[0:4] bridge_hiz_o[1])
    else $error("paired bridge kept driving");
  chk_fault_pin:
    assert property (ot_trip_i || uv_any |-> ##[0:4] adr_fault_oe_o && bridge_hiz_o == 4'hf)
    else $error("fault pin not pulled");
  chk_sda_change:
    assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line moved with clock high");
  chk_ramp_step:
    assert property (!playback_o && !$past(playback_o) && duty_o > $past(duty_o)
                     |-> duty_o == $past(duty_o) + 8'h01)
    else $error("ramp step larger than one");
  chk_mode_par:
    assert property (parallel_bridge_select_i [*4] |-> output_config_o == 2'h1)
    else $error("parallel mode not shown");
  chk_mode_btl:
    assert property (!parallel_bridge_select_i [*4] |-> output_config_o != 2'h1)
    else $error("parallel mode without select");
endmodule // apfc_assertions

bind apfc_top apfc_assertions i_apfc_assertions (
  .mclk_i, .sys_rst_i, .scl_i, .sda_oe_o, .adr_fault_oe_o, .parallel_bridge_select_i, .oc_i,
  .ot_trip_i, .uv_analog_i, .uv_power_stage_i, .bridge_hiz_o, .duty_o, .output_config_o,
  .playback_o
);

// file: verification/apfc_host_model.sv
// serial control host driving the clock and the open-drain data line
module apfc_host_model (
  output logic scl_o,
  output logic sda_low_o,
  input  logic sda_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus: clock stands still high, data released to its pull-up
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // 400 ns period; data moves mid-low, sampled late in high to ride out sync delay
  task automatic bit_x(input logic b, output logic r);
    #100 sda_low_o = !b;
    #100 scl_o = 1'b1;
    #190 r = sda_i;
    #10 scl_o = 1'b0;
  endtask
  // start also serves as repeated start from a low clock
  task automatic start();
    #100 sda_low_o = 1'b0;
    #100 scl_o = 1'b1;
    #100 sda_low_o = 1'b1;
    #100 scl_o = 1'b0;
  endtask
  task automatic stop();
    #100 sda_low_o = 1'b1;
    #100 scl_o = 1'b1;
    #100 sda_low_o = 1'b0;
    #200;
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic rd(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(!more, r);
  endtask
  // register write of n bytes, most significant first; ok is the address ack
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] s, input int n,
                        input logic [31:0] v, output logic ok);
    logic k;
    start();
    wr({a, 1'b0}, ok);
    wr(s, k);
    for (int i = n - 1; i >= 0; i--)
      wr(v[8*i +: 8], k);
    stop();
  endtask
  // register read: pointer write, repeated start, n bytes, nack on the last
  task automatic reg_rd(input logic [6:0] a, input logic [7:0] s, input int n,
                        output logic [31:0] v);
    logic       k;
    logic [7:0] b;
    v = 32'h0;
    start();
    wr({a, 1'b0}, k);
    wr(s, k);
    start();
    wr({a, 1'b1}, k);
    for (int i = n - 1; i >= 0; i--)
    begin
      rd(i != 0, b);
      v = {v[23:0], b};
    end
    stop();
  endtask
endmodule // apfc_host_model

// file: verification/tb_top.sv
// self-checking bench for the protection and fault controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [23:0] UNIT = 24'h00000a;
  logic        mclk_i = 0, sys_rst_i = 1, strap = 1, ok, ot_trip_i = 0, ot_cool_i = 1;
  logic        parallel_bridge_select_i = 0, uv_analog_i = 0;
  logic        por_power_stage_ok_i = 0, por_analog_ok_i = 0;
  logic [1:0]  uv_power_stage_i = 2'h0;
  logic [3:0]  oc_i = 4'h0;
  logic [7:0]  soft_start_timing_pin_i = 8'h03, duty_target_i = 8'h08;
  logic [31:0] v;
  wire         host_low, scl_i, sda_oe_o, adr_fault_oe_o, playback_o;
  wire  [1:0]  output_config_o;
  wire  [3:0]  bridge_hiz_o;
  wire  [7:0]  duty_o;
  wire  [31:0] output_mux_o;
  // open-drain wires: sda_i pulled up, adr_fault_i pulled to strap; low while any party drives
  wire         sda_i = !(host_low | sda_oe_o);
  wire         adr_fault_i = adr_fault_oe_o ? 1'b0 : strap;
  int          fails = 0, tests_run = 0, cyc = 0;
  apfc_top #(.RECOV_UNIT_CYC(UNIT)) i_apfc_top (
    .mclk_i, .sys_rst_i, .scl_i, .sda_i, .sda_o(), .sda_oe_o, .adr_fault_i, .adr_fault_o(),
    .adr_fault_oe_o, .parallel_bridge_select_i, .oc_i, .ot_trip_i, .ot_cool_i, .uv_analog_i,
    .uv_power_stage_i, .por_power_stage_ok_i, .por_analog_ok_i, .soft_start_timing_pin_i,
    .duty_target_i, .bridge_hiz_o, .duty_o, .output_config_o, .output_mux_o, .playback_o);
  apfc_host_model i_apfc_host_model (.scl_o(scl_i), .sda_low_o(host_low), .sda_i);
  initial forever #25 mclk_i = ~mclk_i;
  // the run needs some 7k cycles; the ceiling leaves wide margin
  always @(posedge mclk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fails++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] probe(input int k);
    return k == 0 ? duty_o : k == 1 ? {7'h00, playback_o} : {4'h0, bridge_hiz_o};
  endfunction
  // bounded wait for a watched output to reach a value
  task automatic wait_for(input int k, input logic [7:0] x, output int c);
    c = 0;
    while (probe(k) !== x && c < 400)
    begin
      @(negedge mclk_i);
      c++;
    end
    // a wait that runs out is a mismatch of its own, not a silent pass
    if (probe(k) !== x)
    begin
      fails++;
      $display("ERROR %0t: wait limit on output %0d", $time, k);
    end
  endtask
  task automatic rd_chk(input logic [7:0] s, input int n, input logic [31:0] e);
    i_apfc_host_model.reg_rd(7'h1b, s, n, v);
    check(v, e);
  endtask
  task automatic wr(input logic [7:0] s, input int n, input logic [31:0] d);
    i_apfc_host_model.reg_wr(7'h1b, s, n, d, ok);
  endtask
  // k: 0 overcurrent on C, 1 overtemperature, 2 stage undervoltage, 3 analog undervoltage
  task automatic set_cause(input int k, input logic on);
    oc_i = (k == 0 && on) ? 4'h4 : 4'h0;
    ot_trip_i = k == 1 && on;
    ot_cool_i = !ot_trip_i;
    uv_power_stage_i = {k == 2 && on, 1'b0};
    uv_analog_i = k == 3 && on;
  endtask
  // reset with supplies low, then release them and follow the start-up ramp
  task automatic boot(input logic s);
    int c;
    @(negedge mclk_i);
    strap = s;
    {por_power_stage_ok_i, por_analog_ok_i} = 2'h0;
    sys_rst_i = 1;
    repeat (20) @(negedge mclk_i);
    sys_rst_i = 0;
    repeat (40) @(negedge mclk_i);
    check({playback_o, bridge_hiz_o}, 5'h0f);
    {por_power_stage_ok_i, por_analog_ok_i} = 2'h3;
    wait_for(0, 8'h01, c);
    wait_for(0, 8'h02, c);
    check(c, 4);
    wait_for(1, 8'h01, c);
    check(duty_o, 8'h08);
  endtask
  // wrong address ignored, strap no longer sampled, reset values, mux, modes
  task automatic t_regs();
    i_apfc_host_model.reg_wr(7'h1a, 8'h1c, 1, 32'h07, ok);
    check(ok, 0);
    strap = 0;
    rd_chk(8'h1c, 1, 32'h01);
    rd_chk(8'h02, 1, 32'h00);
    rd_chk(8'h10, 1, 32'h00);
    rd_chk(8'h25, 4, 32'h01002345);
    wr(8'h25, 4, 32'h01103245);
    check(output_mux_o, 32'h01103245);
    wr(8'h05, 1, 32'h04);
    check(output_config_o, 2'h2);
    wr(8'h05, 1, 32'h00);
    check(output_config_o, 2'h0);
    parallel_bridge_select_i = 1;
    repeat (4) @(negedge mclk_i);
    check(output_config_o, 2'h1);
  endtask
  // each cause: all off, re-wait while present, sticky bit and pin until cleared
  task automatic t_faults();
    int c;
    wr(8'h1c, 1, 32'h03);
    for (int k = 0; k < 4; k++)
    begin
      set_cause(k, 1);
      repeat (100) @(negedge mclk_i);
      check(bridge_hiz_o, 4'hf);
      check({adr_fault_oe_o, playback_o}, 2'h2);
      set_cause(k, 0);
      wait_for(1, 8'h01, c);
      check(adr_fault_oe_o, 1);
      rd_chk(8'h02, 1, 32'h1 << (k > 2 ? 2 : k));
      wr(8'h02, 1, 32'h00);
      check(adr_fault_oe_o, 0);
    end
    set_cause(1, 1);
    repeat (2) @(negedge mclk_i);
    set_cause(1, 0);
    // the trip reaches the bridges two sync stages and two registers late: count from hi-z
    wait_for(2, 8'h0f, c);
    wait_for(2, 8'h00, c);
    check(c inside {[28:38]}, 1);
    oc_i = 4'h1;
    repeat (8) @(negedge mclk_i);
    check(bridge_hiz_o, 4'h3);
    oc_i = 4'h0;
    parallel_bridge_select_i = 0;
  endtask
  // strap low: the device answers on the other address only
  task automatic t_strap_low();
    boot(0);
    i_apfc_host_model.reg_wr(7'h1a, 8'h1c, 1, 32'h02, ok);
    check(ok, 1);
    i_apfc_host_model.reg_rd(7'h1a, 8'h1c, 1, v);
    check(v, 32'h02);
    i_apfc_host_model.reg_wr(7'h1b, 8'h1c, 1, 32'h02, ok);
    check(ok, 0);
  endtask
  initial
  begin
    boot(1);
    t_regs();
    t_faults();
    t_strap_low();
    summarize();
  end
endmodule // tb_top
